// File: verilog/cdd_top.sv
// Overview of operation
// - Each channel divides by 1 to 1045, odd or even, at 50% duty.
// - Divide ratios of 26 or more put the channel in extended mode.
// - Optional VCO post-divider divides 2 to 8 at 50% duty.
// - One selection of VCO or post-divided clock feeds path and feedback.
// - Coarse delay 4.5-12 path cycles normal, 12.5-522 VCO cycles extended.
// - Half-step bit gives half-cycle delay steps when divide exceeds 1.
// - New coarse delay waits for the next alignment event.
// - Alignment gives all non-exempt divider outputs a common edge and new delays.
// - Non-exempt reference-sourced outputs go low during alignment, unaligned.
// - Alignment-exempt outputs keep running through alignment.
// - Reference divider 1 to 8; each reference output picks divided or not.
// - Two channels may carry the reference; three reference outputs total.
// - Unprogrammed, channel four runs; channel three and buffer carry ref.
// - Fine delay 25 ps steps to 475 ps plus 500 ps when enabled.
// - Zero-delay feedback selects an internal output or external input.
// - Status pins report lock, holdover, loss; input pin may select input.
`timescale 1ns/1ns
module cdd_top (
  input  wire logic                            i_mclk,
  input  wire logic                            i_reset_n,
  input  wire logic                            i_reference_osc_input,
  input  wire logic                            i_sync,
  input  wire logic                            i_external_feedback_input,
  input  wire logic                            i_input0_status_pin,
  input  wire logic                            i_cfg_load,
  input  wire cdd_pkg::cdd_chan_t [5:0]        i_chan_cfg,
  input  wire cdd_pkg::cdd_glb_t               i_glb_cfg,
  input  wire logic                            i_pll1_lock,
  input  wire logic                            i_holdover,
  input  wire logic                            i_in0_los,
  input  wire logic                            i_readback_data,
  output logic      [5:0][1:0]                 o_clk_out,
  output logic                                 o_reference_buffer_out,
  output logic      [1:0]                      o_pll_fb_clk,
  output logic                                 o_pll1_fb,
  output logic      [5:0]                      o_extended,
  output logic      [5:0][9:0]                 o_fine_dly_ps,
  output logic                                 o_lock_status_pin,
  output logic                                 o_input0_status_pin,
  output logic                                 o_input0_status_oe,
  output logic                                 o_active_in_sel
);

  localparam int NCH = cdd_pkg::NCH;

  // ==========================================================
  // Pin synchronisers: level changes once stages 2 and 3 agree
  logic [3:0] pin_raw, s1, s2, s3, lv, next_lv;
  logic       sync_lv, ref_lv, extfb_lv, in0_lv;

  assign pin_raw = {i_input0_status_pin, i_external_feedback_input,
                    i_reference_osc_input, i_sync};
  assign {in0_lv, extfb_lv, ref_lv, sync_lv} = lv;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      always_comb begin
        next_lv[g] = (s2[g] == s3[g]) ? s3[g] : lv[g];
      end
      always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          lv[g] <= 1'b0;
        end else begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          lv[g] <= next_lv[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Active configuration; reset gives the start-up clocks
  cdd_pkg::cdd_chan_t [5:0] act_ch, next_act_ch;
  cdd_pkg::cdd_glb_t        act_glb, next_act_glb;

  always_comb begin
    next_act_ch  = act_ch;
    next_act_glb = act_glb;
    if (i_cfg_load) begin
      next_act_ch  = i_chan_cfg;
      next_act_glb = i_glb_cfg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NCH; k++) begin
        act_ch[k] <= cdd_pkg::CH_OFF_RST;
      end
      act_ch[3] <= cdd_pkg::CH3_RST;
      act_ch[4] <= cdd_pkg::CH4_RST;
      act_glb   <= cdd_pkg::GLB_RST;
    end else begin
      act_ch  <= next_act_ch;
      act_glb <= next_act_glb;
    end
  end

  // ==========================================================
  // VCO post-divider and path clock select
  logic [1:0] pd_ph;
  logic       pd_rise, tick;

  cdd_div u_postdiv (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_en      (1'b1),
    .i_cnt_en  (1'b1),
    .i_hold    (!act_glb.vco_div_en),
    .i_div     ({7'h00, act_glb.vco_div}),
    .i_dly_h   (11'h000),
    .o_ph      (pd_ph),
    .o_rise    (pd_rise)
  );

  // The same choice clocks channels and the feedback prescaler
  assign tick = act_glb.vco_div_en ? pd_rise : 1'b1;

  logic [1:0] next_fb_clk;

  always_comb begin
    next_fb_clk = act_glb.vco_div_en ? pd_ph : 2'h2;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_pll_fb_clk <= 2'h0;
    end else begin
      o_pll_fb_clk <= next_fb_clk;
    end
  end

  // ==========================================================
  // Reference divider: toggling every div edges keeps 50% duty
  logic       ref_prev, ref_div_q, next_ref_div_q;
  logic [3:0] ref_cnt, next_ref_cnt;

  always_comb begin
    next_ref_cnt   = ref_cnt;
    next_ref_div_q = ref_div_q;
    if (ref_lv != ref_prev) begin
      if (ref_cnt + 4'h1 >= act_glb.ref_div) begin
        next_ref_cnt   = 4'h0;
        next_ref_div_q = !ref_div_q;
      end else begin
        next_ref_cnt = ref_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ref_prev  <= 1'b0;
      ref_cnt   <= 4'h0;
      ref_div_q <= 1'b0;
    end else begin
      ref_prev  <= ref_lv;
      ref_cnt   <= next_ref_cnt;
      ref_div_q <= next_ref_div_q;
    end
  end

  // ==========================================================
  // Channels
  logic [5:0]        hold, ref_ok, ext, forced;
  logic [5:0][10:0]  dly_lat, next_dly_lat;
  logic [5:0][1:0]   ch_ph, next_clk_out;
  logic [5:0][9:0]   next_fine;

  function automatic logic [9:0] fine_ps(input cdd_pkg::cdd_chan_t c);
    logic [4:0] s;
    s = (c.fine_step > cdd_pkg::FINE_MAX_STEP) ?
        cdd_pkg::FINE_MAX_STEP : c.fine_step;
    fine_ps = c.fine_en ? 10'(cdd_pkg::FINE_OFS_PS +
                              cdd_pkg::FINE_STEP_PS * int'(s)) : 10'h000;
  endfunction : fine_ps

  function automatic logic [10:0] dly_halves(input cdd_pkg::cdd_chan_t c);
    dly_halves = {c.ddly, 1'b0} -
                 {10'h000, c.hs && c.div > 11'h001};
  endfunction : dly_halves

  // A channel pair is held between path ticks; the path clock halves
  // pick which half shows, so odd post-divides keep their 50% duty
  function automatic logic [1:0] on_path(input logic [1:0] ph,
                                         input logic [1:0] path);
    on_path = {path[1] ? ph[1] : ph[0], path[0] ? ph[1] : ph[0]};
  endfunction : on_path

  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ext[g]    = act_ch[g].div >= cdd_pkg::EXT_MIN_DIV;
      assign ref_ok[g] = act_ch[g].ref_src &&
                         (g == cdd_pkg::REF_CH_A ||
                          g == cdd_pkg::REF_CH_B);
      assign forced[g] = sync_lv && !act_ch[g].exempt;
      assign hold[g]   = forced[g] || !act_ch[g].en || ref_ok[g];

      cdd_div u_div (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_en      (tick),
        .i_cnt_en  (ext[g] ? 1'b1 : tick),
        .i_hold    (hold[g]),
        .i_div     (act_ch[g].div),
        .i_dly_h   (dly_lat[g]),
        .o_ph      (ch_ph[g]),
        .o_rise    ()
      );

      always_comb begin
        // Delay is captured only while alignment is asserted
        next_dly_lat[g] = sync_lv ? dly_halves(act_ch[g])
                                  : dly_lat[g];
        next_fine[g]    = fine_ps(act_ch[g]);
        if (!act_ch[g].en) begin
          next_clk_out[g] = 2'h0;
        end else if (ref_ok[g]) begin
          // Registered from the synchronised reference level or its divided copy
          next_clk_out[g] = forced[g] ? 2'h0 :
            {2{act_ch[g].ref_div_sel ? ref_div_q : ref_lv}};
        end else begin
          next_clk_out[g] = on_path(ch_ph[g], o_pll_fb_clk);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      dly_lat       <= '0;
      o_clk_out     <= '0;
      o_extended    <= 6'h00;
      o_fine_dly_ps <= '0;
    end else begin
      dly_lat       <= next_dly_lat;
      o_clk_out     <= next_clk_out;
      o_extended    <= ext;
      o_fine_dly_ps <= next_fine;
    end
  end

  // ==========================================================
  // Reference buffer, feedback mux and status pins
  logic next_refbuf, next_fb, next_ld, next_in0, next_oe, next_sel;

  function automatic logic role_val(input logic [2:0] r, input logic rb);
    case (r)
      cdd_pkg::ROLE_LOCK: role_val = i_pll1_lock;
      cdd_pkg::ROLE_HOLD: role_val = i_holdover;
      cdd_pkg::ROLE_LOS:  role_val = i_in0_los;
      cdd_pkg::ROLE_RDBK: role_val = rb;
      default:            role_val = 1'b0;
    endcase
  endfunction : role_val

  always_comb begin
    next_refbuf = act_glb.ref_buf_en && !sync_lv &&
      (act_glb.ref_buf_div_sel ? ref_div_q : ref_lv);
    next_fb = 1'b0;
    if (act_glb.zero_dly) begin
      next_fb = act_glb.fb_ext ? extfb_lv
                               : o_clk_out[act_glb.fb_ch][1];
    end
    next_ld  = role_val(act_glb.ld_role, i_readback_data);
    next_in0 = role_val(act_glb.in0_role, i_readback_data);
    next_oe  = act_glb.in0_role != cdd_pkg::ROLE_SEL;
    // An output-role pin reads as zero for input selection
    next_sel = !next_oe && in0_lv;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_reference_buffer_out <= 1'b0;
      o_pll1_fb              <= 1'b0;
      o_lock_status_pin      <= 1'b0;
      o_input0_status_pin    <= 1'b0;
      o_input0_status_oe     <= 1'b0;
      o_active_in_sel        <= 1'b0;
    end else begin
      o_reference_buffer_out <= next_refbuf;
      o_pll1_fb              <= next_fb;
      o_lock_status_pin      <= next_ld;
      o_input0_status_pin    <= next_in0;
      o_input0_status_oe     <= next_oe;
      o_active_in_sel        <= next_sel;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sequence s_align_on(int k);
    sync_lv && !act_ch[k].exempt && !ref_ok[k];
  endsequence

  a_ext_mode: assert property (
    o_extended[0] == ($past(act_ch[0].div) >= 11'h01A))
    else $error("extended flag does not follow divide ratio");
  a_align_low: assert property (
    s_align_on(0) ##1 s_align_on(0) |=> o_clk_out[0] == 2'h0)
    else $error("aligned channel not held low");
  a_ref_low: assert property (
    sync_lv && ref_ok[3] && !act_ch[3].exempt |=> o_clk_out[3] == 2'h0)
    else $error("reference channel not forced low");
  a_exempt_run: assert property (
    act_ch[2].exempt && act_ch[2].en && !ref_ok[2] |-> !hold[2])
    else $error("exempt channel was held");
  a_delay_keep: assert property (!sync_lv |=> $stable(dly_lat))
    else $error("coarse delay changed without alignment");
  a_refbuf_low: assert property (sync_lv |=> !o_reference_buffer_out)
    else $error("reference buffer not low during alignment");
  a_fine_ofs: assert property (
    act_ch[0].fine_en |=> o_fine_dly_ps[0] >= 10'h1F4 &&
                         o_fine_dly_ps[0] <= 10'h3CF)
    else $error("fine delay outside offset range");
  a_fb_ext: assert property (
    act_glb.zero_dly && act_glb.fb_ext |=> o_pll1_fb == $past(extfb_lv))
    else $error("external feedback not routed");
  a_in_sel: assert property (
    act_glb.in0_role == cdd_pkg::ROLE_SEL |=> !o_input0_status_oe)
    else $error("select-role pin still driven");
  a_sel_off: assert property (
    act_glb.in0_role != cdd_pkg::ROLE_SEL |=> !o_active_in_sel)
    else $error("input select seen while pin is an output");
  a_fb_path: assert property (
    !act_glb.vco_div_en |=> o_pll_fb_clk == 2'h2)
    else $error("undivided path clock not passed on");
  a_startup: assert property (
    !$past(i_reset_n) |-> act_ch[4].en && act_ch[3].ref_src &&
                          act_glb.ref_buf_en)
    else $error("start-up clocks not enabled");

endmodule : cdd_top

// File: verilog/cdd_pkg.sv
package cdd_pkg;

  // ==========================================================
  // Sizes and limits
  localparam int NCH = 6;
  localparam int REF_CH_A = 3;
  localparam int REF_CH_B = 4;
  localparam logic [10:0] EXT_MIN_DIV = 11'h01A;
  localparam logic [4:0]  FINE_MAX_STEP = 5'h13;
  localparam int FINE_STEP_PS = 25;
  localparam int FINE_OFS_PS  = 500;

  // ==========================================================
  // Status pin roles
  localparam logic [2:0] ROLE_LOCK = 3'h0;
  localparam logic [2:0] ROLE_HOLD = 3'h1;
  localparam logic [2:0] ROLE_LOS  = 3'h2;
  localparam logic [2:0] ROLE_RDBK = 3'h3;
  localparam logic [2:0] ROLE_SEL  = 3'h4;

  // ==========================================================
  // Configuration carriers
  typedef struct packed {
    logic        en;
    logic [10:0] div;
    logic [9:0]  ddly;
    logic        hs;
    logic        exempt;
    logic        ref_src;
    logic        ref_div_sel;
    logic        fine_en;
    logic [4:0]  fine_step;
  } cdd_chan_t;

  typedef struct packed {
    logic       vco_div_en;
    logic [3:0] vco_div;
    logic [3:0] ref_div;
    logic       ref_buf_en;
    logic       ref_buf_div_sel;
    logic       zero_dly;
    logic       fb_ext;
    logic [2:0] fb_ch;
    logic [2:0] ld_role;
    logic [2:0] in0_role;
  } cdd_glb_t;

  typedef enum {ST_HOLD, ST_WAIT, ST_RUN} cdd_dstate_t;

  // ==========================================================
  // Start-up values
  localparam cdd_chan_t CH_OFF_RST = '{1'b0, 11'h001, 10'h005, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 5'h00};
  localparam cdd_chan_t CH3_RST = '{1'b1, 11'h001, 10'h005, 1'b0,
    1'b0, 1'b1, 1'b0, 1'b0, 5'h00};
  localparam cdd_chan_t CH4_RST = '{1'b1, 11'h00A, 10'h005, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 5'h00};
  localparam cdd_glb_t GLB_RST = '{1'b0, 4'h2, 4'h1, 1'b1, 1'b0,
    1'b0, 1'b0, 3'h0, ROLE_LOCK, ROLE_LOS};

endpackage : cdd_pkg

// File: verilog/cdd_div.sv
`timescale 1ns/1ns
module cdd_div (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_en,
  input  wire logic        i_cnt_en,
  input  wire logic        i_hold,
  input  wire logic [10:0] i_div,
  input  wire logic [10:0] i_dly_h,
  output logic      [1:0]  o_ph,
  output logic             o_rise
);

  // ==========================================================
  // Half-slot divider: o_ph[1] is the first half of a cycle
  cdd_pkg::cdd_dstate_t st, next_st;
  logic [11:0] q, next_q;
  logic [10:0] wd, next_wd;
  logic [1:0]  next_ph;
  logic        next_rise;
  logic [11:0] q1;

  function automatic logic hi(input logic [11:0] p,
                              input logic [10:0] d);
    hi = p < {1'b0, d};
  endfunction : hi

  function automatic logic [11:0] adv(input logic [11:0] p,
                                      input logic [10:0] d);
    adv = (p + 12'h001 == {d, 1'b0}) ? 12'h000 : p + 12'h001;
  endfunction : adv

  assign q1 = adv(q, i_div);

  always_comb begin
    next_st   = st;
    next_q    = q;
    next_wd   = wd;
    next_ph   = o_ph;
    next_rise = 1'b0;
    case (st)
      cdd_pkg::ST_HOLD: begin
        next_ph = 2'h0;
        next_q  = 12'h000;
        next_wd = i_dly_h;
        next_st = cdd_pkg::ST_WAIT;
      end
      cdd_pkg::ST_WAIT: begin
        if (wd == 11'h000 && i_en) begin
          next_ph   = {hi(q, i_div), hi(q1, i_div)};
          next_q    = adv(q1, i_div);
          next_rise = 1'b1;
          next_st   = cdd_pkg::ST_RUN;
        end else if (wd == 11'h001 && i_en) begin
          next_ph   = 2'h1;
          next_q    = 12'h001;
          next_rise = 1'b1;
          next_st   = cdd_pkg::ST_RUN;
        end else if (wd > 11'h001 && i_cnt_en) begin
          next_wd = wd - 11'h002;
        end
      end
      cdd_pkg::ST_RUN: begin
        if (i_en) begin
          // Odd ratios stay 50% because each half slot counts
          next_ph   = {hi(q, i_div), hi(q1, i_div)};
          next_q    = adv(q1, i_div);
          next_rise = q == 12'h000;
        end
      end
      default: next_st = cdd_pkg::ST_HOLD;
    endcase
    if (i_hold) begin
      next_st   = cdd_pkg::ST_HOLD;
      next_ph   = 2'h0;
      next_rise = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st     <= cdd_pkg::ST_HOLD;
      q      <= 12'h000;
      wd     <= 11'h000;
      o_ph   <= 2'h0;
      o_rise <= 1'b0;
    end else begin
      st     <= next_st;
      q      <= next_q;
      wd     <= next_wd;
      o_ph   <= next_ph;
      o_rise <= next_rise;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  a_hold_low: assert property (i_hold |=> o_ph == 2'h0)
    else $error("divider output not low while held");
  a_half_step: assert property (
    st == cdd_pkg::ST_WAIT && wd == 11'h001 && i_en && !i_hold
    |=> o_ph == 2'h1)
    else $error("half-step start slot wrong");
  a_wait_count: assert property (
    st == cdd_pkg::ST_WAIT && wd > 11'h001 && i_cnt_en && !i_hold
    |=> wd == $past(wd) - 11'h002)
    else $error("delay count not stepping by one cycle");

endmodule : cdd_div

// File: verif/cdd_far_model.sv
`timescale 1ns/1ns
// ==========================================================
// Far side: reference oscillator, feedback trace, host pin
module cdd_far_model #(
  parameter int REF_HALF = 3
) (
  input  wire logic i_mclk,
  input  wire logic i_fb_src,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  input  wire logic i_host_sel,
  output logic      o_ref_osc,
  output logic      o_ext_fb,
  output logic      o_pin
);
  int cnt = 0;
  // Oscillator is a VCXO, so crystal mode stays off from power-up
  initial o_ref_osc = 1'b0;
  always @(negedge i_mclk) begin
    cnt = (cnt + 1) % REF_HALF;
    if (cnt == 0)
      o_ref_osc = ~o_ref_osc;
  end
  // Board trace loops output five back as external feedback
  assign o_ext_fb = i_fb_src;
  // Host drives the select only once the device has released the pin
  assign o_pin = i_pin_oe ? i_pin_out : i_host_sel;
endmodule : cdd_far_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                       i_mclk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       sync = 1'b0;
  logic                       load = 1'b0;
  logic                       host_sel = 1'b0;
  logic [3:0]                 src = 4'h0;
  cdd_pkg::cdd_chan_t [5:0]   chan;
  cdd_pkg::cdd_glb_t          glb;
  logic [5:0][1:0]            o_clk_out;
  logic [1:0]                 o_pll_fb_clk;
  logic [5:0]                 o_extended;
  logic [5:0][9:0]            o_fine_dly_ps;
  logic                       o_reference_buffer_out;
  logic                       o_pll1_fb;
  logic                       lock_pin;
  logic                       pin_out;
  logic                       pin_oe;
  logic                       act_sel;
  logic                       ref_osc;
  logic                       ext_fb;
  logic                       pin;
  int                         err_total = 0;
  int                         num_checks = 0;
  int                         cyc = 0;
  int                         rises[9];
  int                         highs[9];
  int                         first[9];
  int                         dd;
  int                         dl[7] = '{1, 2, 3, 25, 26, 27, 1045};

  always #25 i_mclk = ~i_mclk;

  cdd_far_model far (.i_mclk(i_mclk), .i_fb_src(o_clk_out[5][1]),
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_host_sel(host_sel),
    .o_ref_osc(ref_osc), .o_ext_fb(ext_fb), .o_pin(pin));

  cdd_top dut (.i_mclk(i_mclk), .i_reset_n(rst_n),
    .i_reference_osc_input(ref_osc), .i_sync(sync),
    .i_external_feedback_input(ext_fb), .i_input0_status_pin(pin),
    .i_cfg_load(load), .i_chan_cfg(chan), .i_glb_cfg(glb),
    .i_pll1_lock(src[0]), .i_holdover(src[1]), .i_in0_los(src[2]),
    .i_readback_data(src[3]), .o_clk_out(o_clk_out),
    .o_reference_buffer_out(o_reference_buffer_out),
    .o_pll_fb_clk(o_pll_fb_clk), .o_pll1_fb(o_pll1_fb),
    .o_extended(o_extended), .o_fine_dly_ps(o_fine_dly_ps),
    .o_lock_status_pin(lock_pin), .o_input0_status_pin(pin_out),
    .o_input0_status_oe(pin_oe), .o_active_in_sel(act_sel));

  // ==========================================================
  // Reporting
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic check_val(input string nm, input logic [31:0] seen,
                           input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check_val

  always @(posedge i_mclk) begin
    cyc++;
    // Whole sequence needs about 6k cycles
    if (cyc > 30000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // Bench actions, all entered just after a falling edge
  function automatic logic [8:0] slot(input int h);
    for (int c = 0; c < 6; c++)
      slot[c] = o_clk_out[c][h];
    slot[6] = o_pll_fb_clk[h];
    slot[7] = o_reference_buffer_out;
    slot[8] = o_pll1_fb;
  endfunction : slot

  // Walks slots in time order, first half before second
  task automatic measure(input int n);
    logic [8:0] p;
    logic [8:0] v;
    int s;
    p = slot(0);
    s = 0;
    for (int c = 0; c < 9; c++) begin
      rises[c] = 0;
      highs[c] = 0;
      first[c] = -1;
    end
    repeat (n) begin
      @(negedge i_mclk);
      for (int h = 1; h >= 0; h--) begin
        v = slot(h);
        for (int c = 0; c < 9; c++) begin
          if (v[c] === 1'b1) begin
            highs[c]++;
            if (p[c] !== 1'b1 && first[c] < 0)
              first[c] = s;
            if (p[c] !== 1'b1)
              rises[c]++;
          end
        end
        p = v;
        s++;
      end
    end
  endtask : measure

  task automatic load_cfg();
    load = 1'b1;
    @(negedge i_mclk);
    load = 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask : load_cfg

  // Leaves the window seen while held in rises and highs
  task automatic do_sync();
    sync = 1'b1;
    repeat (8) @(negedge i_mclk);
    measure(4);
    sync = 1'b0;
  endtask : do_sync

  task automatic near(input string nm, input int n, input int e);
    check_val(nm, (n >= e - 1 && n <= e + 1), 1);
  endtask : near

  // ==========================================================
  // Tests
  initial begin
    chan = {6{cdd_pkg::CH_OFF_RST}};
    chan[3] = cdd_pkg::CH3_RST;
    chan[4] = cdd_pkg::CH4_RST;
    glb = cdd_pkg::GLB_RST;
    repeat (6) @(negedge i_mclk);
    check_val("clk_out_rst", o_clk_out, 32'h0);
    rst_n = 1'b1;
    repeat (40) @(negedge i_mclk);
    measure(120);
    check_val("ch4_rises", rises[4], 12);
    check_val("ch4_highs", highs[4], 120);
    near("ch3_rises", rises[3], 20);
    near("buf_rises", rises[7], 20);
    check_val("ch0_off", highs[0], 0);
    $display("test startup done");

    // Host keeps every field inside its defined range
    chan[0].en = 1'b1;
    foreach (dl[i]) begin
      chan[0].div = dl[i];
      chan[0].ddly = (dl[i] >= 26) ? 10'h00D : 10'h005;
      load_cfg();
      check_val("extended", o_extended[0], dl[i] >= 26);
      do_sync();
      repeat (40) @(negedge i_mclk);
      measure(2 * dl[i]);
      check_val("div_rises", rises[0], 2);
      check_val("div_highs", highs[0], 2 * dl[i]);
    end
    $display("test divider done");

    chan[0].div = 11'h004;
    chan[0].ddly = 10'h005;
    chan[1] = chan[0];
    chan[1].ddly = 10'h008;
    chan[2] = chan[0];
    chan[2].div = 11'h002;
    chan[2].exempt = 1'b1;
    load_cfg();
    do_sync();
    check_val("held_ch0", highs[0], 0);
    check_val("held_ch1", highs[1], 0);
    check_val("ref_ch3_low", highs[3], 0);
    check_val("ref_buf_low", highs[7], 0);
    check_val("exempt_run", rises[2], 2);
    measure(80);
    check_val("dly_diff", first[1] - first[0], 6);
    chan[1].ddly = 10'h005;
    load_cfg();
    measure(16);
    dd = ((first[1] - first[0]) % 8 + 8) % 8;
    check_val("dly_pending", dd, 6);
    do_sync();
    measure(80);
    check_val("dly_applied", first[1] - first[0], 0);
    chan[1].hs = 1'b1;
    load_cfg();
    do_sync();
    measure(80);
    check_val("half_step", first[1] - first[0], -1);
    chan[1].hs = 1'b0;
    chan[0].div = 11'h01E;
    chan[1].div = 11'h01E;
    chan[0].ddly = 10'h00D;
    chan[1].ddly = 10'h015;
    load_cfg();
    do_sync();
    measure(120);
    check_val("ext_dly_diff", first[1] - first[0], 16);
    $display("test sync done");

    chan[0].div = 11'h001;
    chan[0].ddly = 10'h005;
    glb.vco_div_en = 1'b1;
    for (int v = 2; v <= 8; v++) begin
      glb.vco_div = v;
      load_cfg();
      do_sync();
      repeat (100) @(negedge i_mclk);
      measure(8 * v);
      check_val("post_rises", rises[0], 8);
      check_val("post_highs", highs[0], 8 * v);
      check_val("fb_rises", rises[6], 8);
      check_val("fb_highs", highs[6], 8 * v);
    end
    glb.vco_div_en = 1'b0;
    $display("test post divider done");

    chan[0].div = 11'h004;
    chan[5] = chan[0];
    glb.zero_dly = 1'b1;
    load_cfg();
    do_sync();
    repeat (40) @(negedge i_mclk);
    measure(32);
    check_val("fb_internal", rises[8], 8);
    glb.fb_ext = 1'b1;
    load_cfg();
    repeat (10) @(negedge i_mclk);
    measure(32);
    check_val("fb_external", rises[8], 8);
    glb.zero_dly = 1'b0;
    load_cfg();
    measure(32);
    check_val("fb_off", highs[8], 0);
    $display("test feedback done");

    for (int s = 0; s <= 20; s += 19) begin
      chan[0].fine_en = 1'b1;
      chan[0].fine_step = s;
      load_cfg();
      check_val("fine_dly", o_fine_dly_ps[0], 500 + 25 * s);
    end
    chan[0].fine_en = 1'b0;
    load_cfg();
    check_val("fine_off", o_fine_dly_ps[0], 0);
    $display("test fine delay done");

    chan[4].ref_src = 1'b1;
    chan[3].ref_div_sel = 1'b1;
    glb.ref_buf_div_sel = 1'b1;
    for (int d = 1; d <= 8; d = d * 2 + (d == 1)) begin
      glb.ref_div = d;
      load_cfg();
      repeat (20) @(negedge i_mclk);
      measure(480);
      near("ref_div_ch3", rises[3], 80 / d);
      near("ref_bypass_ch4", rises[4], 80);
      near("ref_div_buf", rises[7], 80 / d);
    end
    $display("test reference done");

    // Role code 3 is the readback role the host sets before reading
    for (int r = 0; r < 4; r++) begin
      for (int v = 0; v < 2; v++) begin
        src = {4{~v[0]}};
        src[r] = v[0];
        glb.ld_role = r;
        glb.in0_role = r;
        load_cfg();
        repeat (2) @(negedge i_mclk);
        check_val("lock_pin", lock_pin, v);
        check_val("in0_pin", pin_out, v);
        check_val("in0_oe", pin_oe, 1);
      end
    end
    glb.in0_role = cdd_pkg::ROLE_SEL;
    for (int v = 0; v < 2; v++) begin
      host_sel = v[0];
      load_cfg();
      repeat (6) @(negedge i_mclk);
      check_val("sel_oe", pin_oe, 0);
      check_val("active_sel", act_sel, v);
    end
    $display("test status done");
    complete_run();
  end
endmodule : tb_top
